/* File: design/ais_ref_ctrl.sv */
// Reference source decode and on-demand power of the high-speed reference.
`timescale 1ns/1ps
`include "ais_regs.svh"

module ais_ref_ctrl (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Register side.
  ais_ref_if.core bus
);
  import ais_pkg::*;

  localparam ais_ref_st_t REF_RESET = '{
    hs_state: AIS_HS_SLEEP,
    prec_on: 1'b0,
    ref_sel: AIS_REF_HS
  };

  ais_ref_st_t st;
  ais_ref_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.ref_sel = ais_ref_src_t'(bus.ref_src);
    // Precision reference runs only when it is enabled and chosen as source.
    next_st.prec_on = bus.ref_oe && (bus.ref_src == `AIS_SRC_PIN);
    case (st.hs_state)
      AIS_HS_SLEEP: begin
        if (bus.ref_src == `AIS_SRC_HS && bus.conv_active) begin
          next_st.hs_state = AIS_HS_AWAKE;
        end
      end
      AIS_HS_AWAKE: begin
        // Back to low power as soon as the conversion ends or the source moves.
        if (bus.ref_src != `AIS_SRC_HS || !bus.conv_active) begin
          next_st.hs_state = AIS_HS_SLEEP;
        end
      end
      default: begin
        next_st.hs_state = AIS_HS_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= REF_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign bus.hs_ref_on = (st.hs_state == AIS_HS_AWAKE);
  assign bus.prec_ref_on = st.prec_on;
  assign bus.ref_sel = st.ref_sel;
endmodule

/* File: design/ais_top.sv */
// Register file and input multiplexer control of the converter front end.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "ais_regs.svh"

module ais_top #(
  parameter logic [9:0] FACTORY_TEMP_OFFSET = 10'h000
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  // Converter sequencer.
  input wire logic conversion_active,
  // Analog input multiplexer.
  output logic [4:0] analog_input_selector,
  output ais_pkg::ais_input_t input_class,
  output logic channel_reserved,
  output logic temp_sensor_enable,
  // Ground and voltage reference.
  output logic analog_ground_select,
  output ais_pkg::ais_ref_src_t reference_source,
  output logic precision_ref_enable,
  output logic hs_ref_enable
);
  import ais_pkg::*;

  localparam ais_top_st_t TOP_RESET = '{
    chan: `AIS_CHAN_RESET,
    gnd_sel: `AIS_REF_GND_RESET,
    ref_src: `AIS_REF_SRC_RESET,
    temp_en: `AIS_TEMP_EN_RESET,
    ref_oe: `AIS_REF_OE_RESET,
    temp_unprep: 1'b0,
    rdata: 8'h00,
    in_class: AIS_IN_GND,
    rsvd: 1'b0,
    gnd_pin_on: 1'b0,
    temp_on: 1'b0,
    hs_on: 1'b0,
    prec_on: 1'b0,
    ref_sel: AIS_REF_HS
  };

  ais_top_st_t st;
  ais_top_st_t next_st;

  ais_ref_if ref_bus ();

  ais_ref_ctrl u_ref_ctrl (
    .clock(clock),
    .reset_n(reset_n),
    .bus(ref_bus.core)
  );

  // Maps a channel code onto the kind of source that the multiplexer connects.
  function automatic ais_input_t decode_input(input logic [4:0] code);
    ais_input_t cls;
    case (code)
      `AIS_CODE_TEMP: begin
        cls = AIS_IN_TEMP;
      end
      `AIS_CODE_VBAT: begin
        cls = AIS_IN_VBAT;
      end
      `AIS_CODE_VREG: begin
        cls = AIS_IN_VREG;
      end
      `AIS_CODE_VDD: begin
        cls = AIS_IN_VDD;
      end
      `AIS_CODE_GND: begin
        cls = AIS_IN_GND;
      end
      default: begin
        // Pin codes run from zero to the last pin; the rest are reserved.
        if (code <= `AIS_CODE_LAST_PIN) begin
          cls = AIS_IN_PIN;
        end else begin
          cls = AIS_IN_RSVD;
        end
      end
    endcase
    return cls;
  endfunction

  // Builds the reference control image with unused bits at zero.
  function automatic logic [7:0] ref_image(input ais_top_st_t s);
    logic [7:0] img;
    img = 8'h00;
    img[`AIS_REF_GND_BIT] = s.gnd_sel;
    img[`AIS_REF_SRC_MSB:`AIS_REF_SRC_LSB] = s.ref_src;
    img[`AIS_TEMP_EN_BIT] = s.temp_en;
    img[`AIS_REF_OE_BIT] = s.ref_oe;
    return img;
  endfunction

  // Builds the status image from live state.
  function automatic logic [7:0] status_image(input ais_top_st_t s);
    logic [7:0] img;
    img = 8'h00;
    img[`AIS_STAT_RSVD_BIT] = s.rsvd;
    img[`AIS_STAT_UNPREP_BIT] = s.temp_unprep;
    img[`AIS_STAT_HS_BIT] = s.hs_on;
    img[`AIS_STAT_TEMP_OFF_BIT] = (s.in_class == AIS_IN_TEMP) && !s.temp_en;
    return img;
  endfunction

  // Returns the read value of one address; unmapped addresses read zero.
  function automatic logic [7:0] read_image(
    input logic [7:0] addr,
    input ais_top_st_t s
  );
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      `AIS_INPUT_CHANNEL_SELECT_ADDR: begin
        val[`AIS_CHAN_MSB:`AIS_CHAN_LSB] = s.chan;
      end
      `AIS_TEMP_OFFSET_HIGH_ADDR: begin
        val = FACTORY_TEMP_OFFSET[9:2];
      end
      `AIS_TEMP_OFFSET_LOW_ADDR: begin
        val[`AIS_OFS_LOW_MSB:`AIS_OFS_LOW_LSB] = FACTORY_TEMP_OFFSET[1:0];
      end
      `AIS_REFERENCE_CONTROL_ADDR: begin
        val = ref_image(s);
      end
      `AIS_MUX_STATUS_ADDR: begin
        val = status_image(s);
      end
      default: begin
        val = 8'h00;
      end
    endcase
    return val;
  endfunction

  // The reference side sees the stored fields and the live conversion state.
  assign ref_bus.ref_src = st.ref_src;
  assign ref_bus.ref_oe = st.ref_oe;
  assign ref_bus.conv_active = conversion_active;

  always_comb begin
    next_st = st;
    // Read data stands for one cycle only.
    next_st.rdata = 8'h00;

    if (write_strobe) begin
      case (address)
        `AIS_INPUT_CHANNEL_SELECT_ADDR: begin
          // Upper bits of the write are dropped.
          next_st.chan = write_data[`AIS_CHAN_MSB:`AIS_CHAN_LSB];
          // Entering the sensor straight from a live channel is recorded.
          if (write_data[`AIS_CHAN_MSB:`AIS_CHAN_LSB] == `AIS_CODE_TEMP
              && st.chan != `AIS_CODE_GND
              && st.chan != `AIS_CODE_TEMP) begin
            next_st.temp_unprep = 1'b1;
          end
        end
        `AIS_REFERENCE_CONTROL_ADDR: begin
          next_st.gnd_sel = write_data[`AIS_REF_GND_BIT];
          next_st.ref_src = write_data[`AIS_REF_SRC_MSB:`AIS_REF_SRC_LSB];
          next_st.temp_en = write_data[`AIS_TEMP_EN_BIT];
          next_st.ref_oe = write_data[`AIS_REF_OE_BIT];
        end
        `AIS_MUX_STATUS_ADDR: begin
          // Writing one clears the record of a skipped ground step.
          if (write_data[`AIS_STAT_UNPREP_BIT]) begin
            next_st.temp_unprep = 1'b0;
          end
        end
        default: begin
          // Offset registers are read only and other addresses take nothing.
          next_st.chan = st.chan;
        end
      endcase
    end

    if (read_strobe) begin
      next_st.rdata = read_image(address, st);
    end

    // Multiplexer outputs follow the stored code on the same edge.
    next_st.in_class = decode_input(next_st.chan);
    next_st.rsvd = (next_st.in_class == AIS_IN_RSVD);

    // The sensor is driven only while its enable bit is set.
    next_st.temp_on = next_st.temp_en;

    next_st.hs_on = ref_bus.hs_ref_on;
    next_st.prec_on = ref_bus.prec_ref_on;
    next_st.ref_sel = ref_bus.ref_sel;

    // The analog ground pin is left out while sampling the sensor and
    // while the high-speed reference is converting, which use chip ground.
    next_st.gnd_pin_on = next_st.gnd_sel
      && (next_st.in_class != AIS_IN_TEMP)
      && !(ref_bus.hs_ref_on && conversion_active);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= TOP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign read_data = st.rdata;
  assign analog_input_selector = st.chan;
  assign input_class = st.in_class;
  assign channel_reserved = st.rsvd;
  assign temp_sensor_enable = st.temp_on;
  assign analog_ground_select = st.gnd_pin_on;
  assign reference_source = st.ref_sel;
  assign precision_ref_enable = st.prec_on;
  assign hs_ref_enable = st.hs_on;
endmodule

/* File: inc/ais_pkg.sv */
// Types shared by the input and reference select modules.
package ais_pkg;

  typedef enum logic [2:0] {
    AIS_IN_PIN,
    AIS_IN_TEMP,
    AIS_IN_VBAT,
    AIS_IN_VREG,
    AIS_IN_VDD,
    AIS_IN_GND,
    AIS_IN_RSVD
  } ais_input_t;

  typedef enum logic [1:0] {
    AIS_REF_PIN,
    AIS_REF_VDD,
    AIS_REF_CORE,
    AIS_REF_HS
  } ais_ref_src_t;

  typedef enum logic {
    AIS_HS_SLEEP,
    AIS_HS_AWAKE
  } ais_hs_state_t;

  typedef struct packed {
    ais_hs_state_t hs_state;
    logic prec_on;
    ais_ref_src_t ref_sel;
  } ais_ref_st_t;

  typedef struct packed {
    logic [4:0] chan;
    logic gnd_sel;
    logic [1:0] ref_src;
    logic temp_en;
    logic ref_oe;
    logic temp_unprep;
    logic [7:0] rdata;
    ais_input_t in_class;
    logic rsvd;
    logic gnd_pin_on;
    logic temp_on;
    logic hs_on;
    logic prec_on;
    ais_ref_src_t ref_sel;
  } ais_top_st_t;

endpackage

/* File: inc/ais_ref_if.sv */
// Link between the register side and the reference control.
`timescale 1ns/1ps

interface ais_ref_if;
  import ais_pkg::*;
  logic [1:0] ref_src;
  logic ref_oe;
  logic conv_active;
  logic hs_ref_on;
  logic prec_ref_on;
  ais_ref_src_t ref_sel;

  modport regs (
    output ref_src,
    output ref_oe,
    output conv_active,
    input hs_ref_on,
    input prec_ref_on,
    input ref_sel
  );

  modport core (
    input ref_src,
    input ref_oe,
    input conv_active,
    output hs_ref_on,
    output prec_ref_on,
    output ref_sel
  );
endinterface

/* File: inc/ais_regs.svh */
// Register map, field positions, reset values and codes of the input and reference select.
// Notes on behaviour
// - A 5-bit channel code in bits 4:0 picks the input; 11011 temp, 11111 ground.
// - Inputs are port pins, temp sensor, battery, core supply, main supply or ground.
// - Channel register bits 7:5 read as zero and ignore writes.
// - The temp sensor enable bit switches the sensor; disabled it is high impedance.
// - A 10-bit factory offset is held; bits 9:2 read from offset high register.
// - Offset bits 1:0 read in bits 7:6 of the offset low register.
// - Offset low bits 5:0 always read zero and ignore writes.
// - Ground reference is either the device ground pin or the analog ground pin.
// - With source code 11 the high-speed reference powers up and down on its own.
// - The high-speed reference stays in low power whenever no conversion runs.
// - The precision reference is on and used when output enable is 1 and source 00.
// - Source code 01 selects the main supply, code 10 the 1.8 V core supply.
// - The reference source code sits in bits 4:3 of reference control.
// - Reference control bit 5 picks ground pin at 0, analog ground pin at 1.
`ifndef AIS_REGS_SVH
`define AIS_REGS_SVH

`define AIS_TEMP_OFFSET_LOW_ADDR 8'h85
`define AIS_TEMP_OFFSET_HIGH_ADDR 8'h86
`define AIS_INPUT_CHANNEL_SELECT_ADDR 8'hBB
`define AIS_MUX_STATUS_ADDR 8'hBC
`define AIS_REFERENCE_CONTROL_ADDR 8'hD1

`define AIS_CHAN_MSB 4
`define AIS_CHAN_LSB 0
`define AIS_CHAN_RESET 5'h1F

`define AIS_REF_GND_BIT 5
`define AIS_REF_SRC_MSB 4
`define AIS_REF_SRC_LSB 3
`define AIS_TEMP_EN_BIT 2
`define AIS_REF_OE_BIT 0
`define AIS_REF_GND_RESET 1'h0
`define AIS_REF_SRC_RESET 2'h3
`define AIS_TEMP_EN_RESET 1'h0
`define AIS_REF_OE_RESET 1'h0

`define AIS_OFS_LOW_MSB 7
`define AIS_OFS_LOW_LSB 6

`define AIS_STAT_RSVD_BIT 0
`define AIS_STAT_UNPREP_BIT 1
`define AIS_STAT_HS_BIT 2
`define AIS_STAT_TEMP_OFF_BIT 3

`define AIS_CODE_LAST_PIN 5'h0E
`define AIS_CODE_TEMP 5'h1B
`define AIS_CODE_VBAT 5'h1C
`define AIS_CODE_VREG 5'h1D
`define AIS_CODE_VDD 5'h1E
`define AIS_CODE_GND 5'h1F

`define AIS_SRC_PIN 2'h0
`define AIS_SRC_HS 2'h3

`endif

/* File: verif/ais_top_chk.sv */
// Concurrent checks on the ports of the input and reference select.
`timescale 1ns/1ps

module ais_top_chk #(
  parameter logic [9:0] FACTORY_TEMP_OFFSET = 10'h000
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [7:0] read_data,
  // Converter and outputs.
  input wire logic conversion_active,
  input wire logic [4:0] analog_input_selector,
  input ais_pkg::ais_input_t input_class,
  input wire logic channel_reserved,
  input wire logic temp_sensor_enable,
  input wire logic analog_ground_select,
  input ais_pkg::ais_ref_src_t reference_source,
  input wire logic precision_ref_enable,
  input wire logic hs_ref_enable
);
  import ais_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire wr_ch = write_strobe && address == 8'hBB;
  wire wr_ref = write_strobe && address == 8'hD1;

  a_chan_follow: assert property (
    wr_ch |=> analog_input_selector == $past(write_data[4:0])) else $error("selector");
  a_chan_resv: assert property (
    wr_ch |=> channel_reserved == ($past(write_data[4:0]) inside {[5'h0F:5'h1A]}))
    else $error("reserved flag");
  a_chan_temp: assert property (
    wr_ch && write_data[4:0] == 5'h1B |=> input_class == AIS_IN_TEMP) else $error("temp");
  a_chan_upper: assert property (
    read_strobe && address == 8'hBB |=> read_data[7:5] == 3'h0) else $error("upper bits");
  a_ofs_high: assert property (
    read_strobe && address == 8'h86 |=> read_data == FACTORY_TEMP_OFFSET[9:2])
    else $error("offset high");
  a_ofs_low: assert property (
    read_strobe && address == 8'h85 |=> read_data == {FACTORY_TEMP_OFFSET[1:0], 6'h00})
    else $error("offset low");
  a_src_decode: assert property (
    wr_ref |-> ##3 reference_source == $past(write_data[4:3], 3)) else $error("source");
  a_prec_on: assert property (
    wr_ref |-> ##3 precision_ref_enable == ($past(write_data[4:0], 3) ==? 5'b00??1))
    else $error("precision");
  a_temp_bit: assert property (
    wr_ref |=> temp_sensor_enable == $past(write_data[2])) else $error("temp enable");
  a_hs_sleep: assert property (
    !conversion_active |-> ##2 !hs_ref_enable) else $error("hs awake idle");
  a_hs_wake: assert property (
    conversion_active && reference_source == AIS_REF_HS && !$past(wr_ref)
    && !$past(wr_ref, 2) |-> ##2 hs_ref_enable)
    else $error("hs asleep");
  a_gnd_sel: assert property (
    wr_ref && !conversion_active && input_class != AIS_IN_TEMP
    |=> analog_ground_select == $past(write_data[5])) else $error("ground select");
endmodule

bind ais_top ais_top_chk #(.FACTORY_TEMP_OFFSET(FACTORY_TEMP_OFFSET)) i_chk (
  .clock(clock), .reset_n(reset_n), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .conversion_active(conversion_active), .analog_input_selector(analog_input_selector),
  .input_class(input_class), .channel_reserved(channel_reserved),
  .temp_sensor_enable(temp_sensor_enable), .analog_ground_select(analog_ground_select),
  .reference_source(reference_source), .precision_ref_enable(precision_ref_enable),
  .hs_ref_enable(hs_ref_enable));

/* File: verif/test_adc_input_and_reference_select.sv */
// Directed register-level test of the input and reference select.
`timescale 1ns/1ps

module test_adc_input_and_reference_select;
  import ais_pkg::*;
  localparam logic [9:0] OFS = 10'h2D6;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic conversion_active = 1'b0;
  logic [7:0] read_data;
  logic [7:0] rd;
  logic [4:0] sel;
  ais_input_t input_class;
  ais_ref_src_t ref_src;
  logic ch_rsvd, temp_en, gnd_sel, prec_en, hs_en;
  int n_mismatch = 0;
  int total_checks = 0;

  ais_top #(.FACTORY_TEMP_OFFSET(OFS)) i_dut (
    .clock(clock), .reset_n(reset_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .conversion_active(conversion_active), .analog_input_selector(sel),
    .input_class(input_class), .channel_reserved(ch_rsvd), .temp_sensor_enable(temp_en),
    .analog_ground_select(gnd_sel), .reference_source(ref_src),
    .precision_ref_enable(prec_en), .hs_ref_enable(hs_en));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    rd = read_data;
    chk(rd, exp);
  endtask

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  function automatic ais_input_t cls(input logic [4:0] c);
    case (c)
      5'h1B: return AIS_IN_TEMP;
      5'h1C: return AIS_IN_VBAT;
      5'h1D: return AIS_IN_VREG;
      5'h1E: return AIS_IN_VDD;
      5'h1F: return AIS_IN_GND;
      default: return (c <= 5'h0E) ? AIS_IN_PIN : AIS_IN_RSVD;
    endcase
  endfunction

  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    step();
    chk({3'h0, sel}, 8'h1F);
    chk({6'h0, ref_src}, 8'h03);
    rchk(8'hBB, 8'h1F);
    rchk(8'hD1, 8'h18);
    rchk(8'h86, OFS[9:2]);
    wr(8'h85, 8'hFF);
    rchk(8'h85, {OFS[1:0], 6'h00});
    rchk(8'h00, 8'h00);
    for (int c = 0; c < 32; c++) begin
      wr(8'hBB, {3'h7, c[4:0]});
      step();
      chk({3'h0, sel}, {3'h0, c[4:0]});
      chk({5'h0, input_class}, {5'h0, cls(c[4:0])});
      chk({7'h0, ch_rsvd}, {7'h0, (c >= 15 && c <= 26)});
      rchk(8'hBB, {3'h0, c[4:0]});
    end
    rchk(8'hBC, 8'h02);
    wr(8'hBC, 8'h02);
    rchk(8'hBC, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'hD1, {3'h6, s[1:0], 3'h7});
      repeat (2) step();
      chk({6'h0, ref_src}, {6'h0, s[1:0]});
      chk({7'h0, prec_en}, {7'h0, s == 0});
      chk({7'h0, temp_en}, 8'h01);
      rchk(8'hD1, {3'h0, s[1:0], 3'h5});
    end
    wr(8'hD1, 8'h38);
    step();
    chk({7'h0, gnd_sel}, 8'h01);
    chk({7'h0, temp_en}, 8'h00);
    @(posedge clock);
    conversion_active <= 1'b1;
    step();
    chk({7'h0, hs_en}, 8'h00);
    step();
    chk({7'h0, hs_en}, 8'h01);
    step();
    chk({7'h0, gnd_sel}, 8'h00);
    @(posedge clock);
    conversion_active <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({7'h0, hs_en}, 8'h00);
    wr(8'hBB, 8'h1B);
    step();
    chk({7'h0, gnd_sel}, 8'h00);
    wr(8'hD1, 8'h20);
    @(posedge clock);
    conversion_active <= 1'b1;
    repeat (3) step();
    chk({7'h0, hs_en}, 8'h00);
    chk({6'h0, ref_src}, 8'h00);
    chk({7'h0, prec_en}, 8'h00);
    rchk(8'hBC, 8'h08);
    @(posedge clock);
    conversion_active <= 1'b0;
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    step();
    chk({3'h0, sel}, 8'h1F);
    chk({7'h0, gnd_sel}, 8'h00);
    rchk(8'hD1, 8'h18);
    report_and_stop();
  end
endmodule
